// ### rtl/descriptor_type_gate_check.sv
// Descriptor type decoder and call-gate / conforming-code privilege checker.
// Assumes a same-clock requester, a descriptor fetch port answering with the
// destination high word, and a same-clock register master.
//
// Overview of operation
// R1 - S clear: decode system types; 0000, 1000, 1010, 1101 reserved
// R2 - S set, type bit 11 clear: data, expand-down, writable, accessed bits
// R3 - S set, type bit 11 set: code, conforming, readable, accessed bits
// R4 - Gate codes: 16-bit call/int/trap, task gate, 32-bit call/int/trap
// R5 - Target offset from both words; selector from low word bits 31:16
// R6 - Gate present bit 15, privilege bits 14:13, type bits 11:8
// R7 - Five-bit parameter count; copy that many parameters between stacks
// R8 - Call gate selector fetches the destination code segment descriptor
// R9 - Larger of current and requested privilege must not exceed gate privilege
// R10 - Jump needs destination privilege equal; call needs it less or equal
// R11 - Conforming code segment may be entered directly without a gate
// R12 - Privilege 00 is highest, 11 lowest, in every comparison
// R13 - Gate upper word bits 7:5 and 12 are expected zero
`timescale 1ns/10ps
module descriptor_type_gate_check
  import descriptor_gate_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input logic [ADDR_W-1:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  input logic xfer_valid,
  input xfer_req_s xfer_req,
  output logic xfer_ready,
  output logic dest_fetch,
  output logic [15:0] dest_selector,
  input logic dest_ack,
  input logic [31:0] dest_hi,
  output logic copy_strobe,
  output logic [4:0] copy_index,
  output logic result_valid,
  output xfer_result_s result
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_COPY = 4'b1000
  } state_e;

  state_e state_ff, nxt_state;
  xfer_req_s req_ff, nxt_req;
  gate_fields_s gate_ff, nxt_gate;
  xfer_result_s res_ff, nxt_res;
  logic ready_ff, nxt_ready;
  logic fetch_ff, nxt_fetch;
  logic [15:0] dsel_ff, nxt_dsel;
  logic copy_ff, nxt_copy;
  logic [4:0] idx_ff, nxt_idx;
  // Separate index register keeps the output straight from a flop
  logic [4:0] cidx_ff, nxt_cidx;
  logic res_valid_ff, nxt_res_valid;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;

  logic done;
  fault_e flt;
  desc_class_s cls;
  desc_class_s dcls;
  logic [1:0] eff_priv;
  logic [1:0] dest_priv;

  // Transfer sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_gate = gate_ff;
    nxt_res = res_ff;
    nxt_ready = ready_ff;
    nxt_fetch = 1'b0;
    nxt_dsel = dsel_ff;
    nxt_copy = 1'b0;
    nxt_idx = idx_ff;
    nxt_cidx = cidx_ff;
    nxt_res_valid = 1'b0;
    done = 1'b0;
    flt = F_NONE;
    // R1 R2 R3 R4 type decode
    cls = class_of(req_ff.desc_hi);
    dcls = class_of(dest_hi);
    dest_priv = dest_hi[PRIV_HI:PRIV_LO];
    // R9 max of current and requested
    eff_priv = (req_ff.current_privilege > req_ff.requested_privilege) ?
      req_ff.current_privilege : req_ff.requested_privilege;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (xfer_valid)
        begin
          nxt_req = xfer_req;
          // R5 R6 R7 gate unpack
          nxt_gate = unpack_gate(xfer_req.desc_lo, xfer_req.desc_hi);
          nxt_ready = 1'b0;
          nxt_idx = PARAM_RESET;
          nxt_state = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        nxt_res.kind = cls.kind;
        nxt_res.params = gate_ff.params;
        nxt_res.conforming = 1'b0;
        if (cls.kind == K_CALL_GATE)
        begin
          nxt_res.offset = gate_ff.offset;
          nxt_res.selector = gate_ff.selector;
          if (!gate_ff.present)
          begin
            flt = F_GATE_ABSENT;
            done = 1'b1;
          end
          // R13 zero bits check
          else if (ctrl_ff[CTRL_STRICT_BIT] && !gate_ff.zero_ok)
          begin
            flt = F_GATE_ZERO_BITS;
            done = 1'b1;
          end
          // R9 R12 gate privilege
          else if (!priv_le(eff_priv, gate_ff.priv))
          begin
            flt = F_GATE_PRIV;
            done = 1'b1;
          end
          else
          begin
            // R8 fetch destination
            nxt_fetch = 1'b1;
            nxt_dsel = gate_ff.selector;
            nxt_state = ST_FETCH;
          end
        end
        else if (cls.kind == K_CODE)
        begin
          nxt_res.offset = 32'h0000_0000;
          nxt_res.selector = 16'h0000;
          nxt_res.conforming = cls.b10;
          // R11 conforming direct entry
          if (cls.b10)
          begin
            flt = priv_le(req_ff.desc_hi[PRIV_HI:PRIV_LO], req_ff.current_privilege) ? F_NONE : F_DIRECT_PRIV;
          end
          else
          begin
            flt = (req_ff.desc_hi[PRIV_HI:PRIV_LO] == req_ff.current_privilege) ? F_NONE : F_DIRECT_PRIV;
          end
          if (flt == F_NONE && !req_ff.desc_hi[PRES_BIT])
          begin
            flt = F_DEST_ABSENT;
          end
          done = 1'b1;
        end
        else
        begin
          flt = F_NOT_GATE;
          done = 1'b1;
        end
      end
      ST_FETCH:
      begin
        if (dest_ack)
        begin
          nxt_res.conforming = dcls.b10;
          if (dcls.kind != K_CODE)
          begin
            flt = F_DEST_NOT_CODE;
          end
          else if (!dest_hi[PRES_BIT])
          begin
            flt = F_DEST_ABSENT;
          end
          // R10 R12 destination privilege
          else if (req_ff.is_call ? !priv_le(dest_priv, req_ff.current_privilege)
                                  : (dest_priv != req_ff.current_privilege))
          begin
            flt = F_DEST_PRIV;
          end
          // R7 parameter copy on calls
          if (flt == F_NONE && req_ff.is_call && ctrl_ff[CTRL_COPY_BIT] && gate_ff.params != PARAM_RESET)
          begin
            nxt_state = ST_COPY;
          end
          else
          begin
            done = 1'b1;
          end
        end
      end
      ST_COPY:
      begin
        // R7 one strobe per parameter
        nxt_copy = 1'b1;
        nxt_cidx = idx_ff;
        nxt_idx = idx_ff + 5'h01;
        if (nxt_idx == gate_ff.params)
        begin
          done = 1'b1;
        end
      end
    endcase
    if (done)
    begin
      nxt_res.ok = (flt == F_NONE);
      nxt_res.fault = flt;
      nxt_res_valid = 1'b1;
      nxt_ready = 1'b1;
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      req_ff <= '0;
      gate_ff <= '0;
      res_ff <= '0;
      ready_ff <= 1'b1;
      fetch_ff <= 1'b0;
      dsel_ff <= 16'h0000;
      copy_ff <= 1'b0;
      idx_ff <= PARAM_RESET;
      cidx_ff <= PARAM_RESET;
      res_valid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      gate_ff <= nxt_gate;
      res_ff <= nxt_res;
      ready_ff <= nxt_ready;
      fetch_ff <= nxt_fetch;
      dsel_ff <= nxt_dsel;
      copy_ff <= nxt_copy;
      idx_ff <= nxt_idx;
      cidx_ff <= nxt_cidx;
      res_valid_ff <= nxt_res_valid;
    end
  end

  // Register port; read data only in the cycle after the strobe
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == REG_CTRL)
    begin
      nxt_ctrl = reg_wdata[1:0];
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL: nxt_rdata = {30'h0, ctrl_ff};
        REG_STATUS: nxt_rdata = {17'h0, res_ff.params, !ready_ff, res_ff.ok, res_ff.fault, res_ff.kind};
        REG_LAST_OFFSET: nxt_rdata = res_ff.offset;
        REG_LAST_SELECTOR: nxt_rdata = {15'h0, res_ff.conforming, res_ff.selector};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_ff <= CTRL_RESET;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign xfer_ready = ready_ff;
  assign dest_fetch = fetch_ff;
  assign dest_selector = dsel_ff;
  assign copy_strobe = copy_ff;
  assign copy_index = cidx_ff;
  assign result_valid = res_valid_ff;
  assign result = res_ff;

endmodule : descriptor_type_gate_check

// ### rtl/descriptor_gate_pkg.sv
// Constants, types and decode functions for the descriptor type and gate checker.
// Assumes descriptor words arrive as the low (+0) and high (+4) 32-bit words.
package descriptor_gate_pkg;

  // Field positions in the high descriptor word
  localparam int unsigned S_BIT = 12;
  localparam int unsigned TYPE_HI = 11;
  localparam int unsigned TYPE_LO = 8;
  localparam int unsigned PRES_BIT = 15;
  localparam int unsigned PRIV_HI = 14;
  localparam int unsigned PRIV_LO = 13;
  localparam int unsigned PARAM_HI = 4;
  localparam int unsigned PARAM_LO = 0;
  localparam int unsigned ZERO_HI = 7;
  localparam int unsigned ZERO_LO = 5;
  // Split offset and selector positions, then type bit positions
  localparam int unsigned WORD_HI_HI = 31;
  localparam int unsigned WORD_HI_LO = 16;
  localparam int unsigned WORD_LO_HI = 15;
  localparam int unsigned WORD_LO_LO = 0;
  localparam int unsigned TB_EXEC = 3;
  localparam int unsigned TB_B10 = 2;
  localparam int unsigned TB_B9 = 1;
  localparam int unsigned TB_ACC = 0;

  // System and gate type codes
  localparam logic [3:0] T_TASK_STATE16_AVAIL = 4'h1;
  localparam logic [3:0] T_LOCAL_TABLE = 4'h2;
  localparam logic [3:0] T_TASK_STATE16_BUSY = 4'h3;
  localparam logic [3:0] T_CALL16 = 4'h4;
  localparam logic [3:0] T_TASK = 4'h5;
  localparam logic [3:0] T_INT16 = 4'h6;
  localparam logic [3:0] T_TRAP16 = 4'h7;
  localparam logic [3:0] T_TASK_STATE32_AVAIL = 4'h9;
  localparam logic [3:0] T_TASK_STATE32_BUSY = 4'hb;
  localparam logic [3:0] T_CALL32 = 4'hc;
  localparam logic [3:0] T_INT32 = 4'he;
  localparam logic [3:0] T_TRAP32 = 4'hf;

  // Register map and reset values
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST_OFFSET = 8'h08;
  localparam logic [7:0] REG_LAST_SELECTOR = 8'h0c;
  localparam int unsigned CTRL_STRICT_BIT = 0;
  localparam int unsigned CTRL_COPY_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [4:0] PARAM_RESET = 5'h00;

  typedef enum logic [3:0] {
    K_RESERVED, K_LOCAL_TABLE, K_TASK_STATE_AVAIL, K_TASK_STATE_BUSY, K_CALL_GATE, K_TASK_GATE,
    K_INT_GATE, K_TRAP_GATE, K_DATA, K_CODE
  } desc_kind_e;

  typedef enum logic [3:0] {
    F_NONE, F_NOT_GATE, F_GATE_ABSENT, F_GATE_ZERO_BITS, F_GATE_PRIV,
    F_DEST_NOT_CODE, F_DEST_ABSENT, F_DEST_PRIV, F_DIRECT_PRIV
  } fault_e;

  typedef struct packed {
    desc_kind_e kind;
    logic wide;
    logic b10;
    logic b9;
    logic accessed;
  } desc_class_s;

  typedef struct packed {
    logic [31:0] offset;
    logic [15:0] selector;
    logic present;
    logic [1:0] priv;
    logic [3:0] gtype;
    logic [4:0] params;
    logic zero_ok;
  } gate_fields_s;

  typedef struct packed {
    logic is_call;
    logic [1:0] current_privilege;
    logic [1:0] requested_privilege;
    logic [31:0] desc_lo;
    logic [31:0] desc_hi;
  } xfer_req_s;

  typedef struct packed {
    logic ok;
    fault_e fault;
    desc_kind_e kind;
    logic conforming;
    logic [31:0] offset;
    logic [15:0] selector;
    logic [4:0] params;
  } xfer_result_s;

  function automatic desc_class_s class_of(input logic [31:0] hi);
    desc_class_s c;
    logic [3:0] t;
    c = '0;
    t = hi[TYPE_HI:TYPE_LO];
    c.b10 = t[TB_B10];
    c.b9 = t[TB_B9];
    c.accessed = t[TB_ACC];
    c.wide = t[TB_EXEC];
    if (hi[S_BIT])
    begin
      c.kind = t[TB_EXEC] ? K_CODE : K_DATA;
    end
    else
    begin
      unique case (t)
        T_LOCAL_TABLE: c.kind = K_LOCAL_TABLE;
        T_TASK_STATE16_AVAIL, T_TASK_STATE32_AVAIL: c.kind = K_TASK_STATE_AVAIL;
        T_TASK_STATE16_BUSY, T_TASK_STATE32_BUSY: c.kind = K_TASK_STATE_BUSY;
        T_CALL16, T_CALL32: c.kind = K_CALL_GATE;
        T_TASK: c.kind = K_TASK_GATE;
        T_INT16, T_INT32: c.kind = K_INT_GATE;
        T_TRAP16, T_TRAP32: c.kind = K_TRAP_GATE;
        default: c.kind = K_RESERVED;
      endcase
    end
    return c;
  endfunction : class_of

  function automatic gate_fields_s unpack_gate(input logic [31:0] lo, input logic [31:0] hi);
    gate_fields_s g;
    g.offset = {hi[WORD_HI_HI:WORD_HI_LO], lo[WORD_LO_HI:WORD_LO_LO]};
    g.selector = lo[WORD_HI_HI:WORD_HI_LO];
    g.present = hi[PRES_BIT];
    g.priv = hi[PRIV_HI:PRIV_LO];
    g.gtype = hi[TYPE_HI:TYPE_LO];
    g.params = hi[PARAM_HI:PARAM_LO];
    g.zero_ok = (hi[ZERO_HI:ZERO_LO] == 3'h0) && !hi[S_BIT];
    return g;
  endfunction : unpack_gate

  // Numerically lower is more privileged, so "at least as privileged" is <=
  function automatic logic priv_le(input logic [1:0] a, input logic [1:0] b);
    return a <= b;
  endfunction : priv_le

endpackage : descriptor_gate_pkg

// ### sim/desc_gate_checker.sv
// Concurrent checks on the descriptor type and gate checker ports.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/10ps
module desc_gate_checker
  import descriptor_gate_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic xfer_valid,
  input xfer_req_s xfer_req,
  input logic xfer_ready,
  input logic dest_fetch,
  input logic [15:0] dest_selector,
  input logic dest_ack,
  input logic [31:0] dest_hi,
  input logic copy_strobe,
  input logic [4:0] copy_index,
  input logic result_valid,
  input xfer_result_s result
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  xfer_req_s rq_ff;
  logic [31:0] dh_ff;
  logic gate_ok;
  // Request is only qualified at the take edge, so keep it for later checks
  always_ff @(posedge ref_clk)
  begin
    if (xfer_valid && xfer_ready)
      rq_ff <= xfer_req;
    if (dest_ack)
      dh_ff <= dest_hi;
  end
  assign gate_ok = result_valid && result.ok && result.kind == K_CALL_GATE;
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data not zero");
  a_take_busy: assert property (xfer_valid && xfer_ready |=> !xfer_ready) else $error("ready stayed high");
  a_answer_two: assert property (xfer_valid && xfer_ready |-> ##2 (dest_fetch || result_valid))
    else $error("no answer two cycles after take");
  a_fetch_sel: assert property (dest_fetch |-> dest_selector == rq_ff.desc_lo[31:16])
    else $error("wrong fetch selector");
  a_gate_fields: assert property (gate_ok |-> result.offset == {rq_ff.desc_hi[31:16], rq_ff.desc_lo[15:0]}
    && result.selector == rq_ff.desc_lo[31:16] && result.params == rq_ff.desc_hi[4:0]) else $error("gate fields");
  a_gate_priv: assert property (gate_ok |-> rq_ff.current_privilege <= rq_ff.desc_hi[14:13]
    && rq_ff.requested_privilege <= rq_ff.desc_hi[14:13]) else $error("gate privilege passed");
  a_jump_equal: assert property (gate_ok && !rq_ff.is_call |-> dh_ff[14:13] == rq_ff.current_privilege)
    else $error("jump privilege");
  a_copy_call: assert property (copy_strobe |-> rq_ff.is_call && rq_ff.desc_hi[4:0] != 5'h00)
    else $error("copy without call");
  a_copy_first: assert property (copy_strobe && !$past(copy_strobe) |-> copy_index == 5'h00)
    else $error("copy index not zero");
  a_seg_kind: assert property (result_valid && rq_ff.desc_hi[12]
    |-> result.kind == (rq_ff.desc_hi[11] ? K_CODE : K_DATA)) else $error("segment kind");
  a_result_ready: assert property (result_valid |-> xfer_ready) else $error("not ready with result");
  c_gate_ok: cover property (gate_ok && rq_ff.is_call);
  c_copy: cover property (copy_strobe ##1 copy_strobe);
  c_direct: cover property (result_valid && result.ok && result.kind == K_CODE);
endmodule : desc_gate_checker

bind descriptor_type_gate_check desc_gate_checker i_chk (.ref_clk, .rst, .reg_rd, .reg_rdata, .xfer_valid,
  .xfer_req, .xfer_ready, .dest_fetch, .dest_selector, .dest_ack, .dest_hi, .copy_strobe, .copy_index,
  .result_valid, .result);

// ### sim/testbench.sv
// Self-checking bench for the descriptor type and gate checker.
// Assumes the bench answers destination fetches one cycle later.
`timescale 1ns/10ps
module testbench;
  import descriptor_gate_pkg::*;
  logic ref_clk, rst, reg_wr, reg_rd, xfer_valid, xfer_ready, dest_fetch, dest_ack;
  logic copy_strobe, result_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, dest_hi, rd;
  logic [15:0] dest_selector;
  logic [4:0] copy_index;
  xfer_req_s xfer_req;
  xfer_result_s result;
  int error_cnt, cmp_count, cyc, nc;
  descriptor_type_gate_check i_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .xfer_valid, .xfer_req, .xfer_ready, .dest_fetch, .dest_selector, .dest_ack, .dest_hi, .copy_strobe,
    .copy_index, .result_valid, .result);
  initial
  begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  always @(posedge ref_clk)
  begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 5000)
    begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : reg_read
  // One transfer; answers every fetch with dh and counts parameter copies
  task automatic run(input logic c, input logic [1:0] cp, rp, input logic [31:0] lo, hi, dh);
    int n;
    n = 0;
    nc = 0;
    xfer_valid <= 1;
    xfer_req <= {c, cp, rp, lo, hi};
    dest_hi <= dh;
    @(posedge ref_clk);
    xfer_valid <= 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      dest_ack <= dest_fetch;
      if (dest_fetch)
        chk("fetch selector", lo[31:16], dest_selector);
      if (copy_strobe)
      begin
        chk("copy index", nc, copy_index);
        nc++;
      end
    end while (!result_valid && n < 40);
    chk("result valid", 1, result_valid);
  endtask : run
  function automatic desc_kind_e ek(input logic [4:0] st);
    if (st[4])
      return st[3] ? K_CODE : K_DATA;
    case (st[3:0])
      2: return K_LOCAL_TABLE;
      1, 9: return K_TASK_STATE_AVAIL;
      3, 11: return K_TASK_STATE_BUSY;
      4, 12: return K_CALL_GATE;
      5: return K_TASK_GATE;
      6, 14: return K_INT_GATE;
      7, 15: return K_TRAP_GATE;
      default: return K_RESERVED;
    endcase
  endfunction : ek
  // Every type code with S clear and set; only code segments are entered
  task automatic test_decode;
    logic [4:0] st;
    for (int i = 0; i < 32; i++)
    begin
      st = i[4:0];
      run(0, 2'h0, 2'h0, 32'h0000_0000, {16'h0000, st[4], 2'h0, st, 8'h00}, 32'h0000_0000);
      chk("kind", ek(st), result.kind);
      chk("ok", st[4] & st[3], result.ok);
      chk("fault", st[4] ? {3'h0, ~st[3]} : ((st[2:0] == 3'h4) ? 4'h2 : 4'h1), result.fault);
      if (st[4] & st[3])
        chk("conforming", st[2], result.conforming);
    end
  endtask : test_decode
  task automatic test_direct;
    run(0, 2'h3, 2'h3, 32'h0000_0000, 32'h0000_9c00, 32'h0000_0000);
    chk("conform ok", 1, result.ok);
    run(0, 2'h3, 2'h3, 32'h0000_0000, 32'h0000_9a00, 32'h0000_0000);
    chk("direct fault", F_DIRECT_PRIV, result.fault);
  endtask : test_direct
  task automatic gc(input logic c, input logic [1:0] cp, rp, gd, input logic [3:0] t, input logic [2:0] z,
    input logic [1:0] dd, input logic [4:0] ds, input logic [3:0] ef, input int ecp);
    run(c, cp, rp, 32'h1234_5678, {16'habcd, 1'b1, gd, 1'b0, t, z, 5'h03}, {16'h0000, 1'b1, dd, ds, 8'h00});
    chk("gate fault", ef, result.fault);
    chk("copies", ecp, nc);
    if (ef == 0)
    begin
      chk("offset", 32'habcd_5678, result.offset);
      chk("selector", 16'h1234, result.selector);
      chk("params", 5'h03, result.params);
    end
  endtask : gc
  task automatic test_gates;
    gc(1, 2'h3, 2'h3, 2'h3, 4'hc, 3'h0, 2'h0, 5'h1a, 4'h0, 3);
    gc(1, 2'h0, 2'h3, 2'h2, 4'h4, 3'h0, 2'h0, 5'h1a, 4'h4, 0);
    gc(1, 2'h0, 2'h0, 2'h0, 4'h4, 3'h0, 2'h0, 5'h1a, 4'h0, 3);
    gc(0, 2'h1, 2'h0, 2'h3, 4'hc, 3'h0, 2'h0, 5'h1a, 4'h7, 0);
    gc(0, 2'h2, 2'h2, 2'h3, 4'h4, 3'h0, 2'h2, 5'h1a, 4'h0, 0);
    gc(1, 2'h0, 2'h0, 2'h3, 4'hc, 3'h0, 2'h3, 5'h1a, 4'h7, 0);
    gc(1, 2'h3, 2'h3, 2'h3, 4'hc, 3'h1, 2'h0, 5'h1a, 4'h3, 0);
    gc(1, 2'h3, 2'h3, 2'h3, 4'hc, 3'h0, 2'h0, 5'h12, 4'h5, 0);
  endtask : test_gates
  task automatic test_regs;
    reg_read(REG_CTRL, rd);
    chk("ctrl reset", 32'h0000_0003, rd);
    reg_write(REG_CTRL, 32'h0000_0001);
    reg_read(REG_CTRL, rd);
    chk("ctrl", 32'h0000_0001, rd);
    reg_read(8'h40, rd);
    chk("unmapped", 32'h0000_0000, rd);
    gc(1, 2'h3, 2'h3, 2'h3, 4'hc, 3'h0, 2'h0, 5'h1a, 4'h0, 0);
    reg_read(REG_STATUS, rd);
    chk("status", 32'h0000_0d04, rd);
    reg_read(REG_LAST_OFFSET, rd);
    chk("last offset", 32'habcd_5678, rd);
    reg_read(REG_LAST_SELECTOR, rd);
    chk("last selector", 32'h0000_1234, rd);
    // Strict check off: nonzero reserved bits pass, copy enabled
    reg_write(REG_CTRL, 32'h0000_0002);
    gc(1, 2'h3, 2'h3, 2'h3, 4'hc, 3'h5, 2'h0, 5'h1a, 4'h0, 3);
    reg_write(REG_CTRL, 32'h0000_0003);
  endtask : test_regs
  initial
  begin
    rst = 1;
    {reg_wr, reg_rd, xfer_valid, dest_ack} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    dest_hi = '0;
    xfer_req = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    test_regs();
    test_decode();
    test_direct();
    test_gates();
    close_out();
  end
endmodule : testbench
